/* tb/clx_exec_asserts.sv */
// Bus handshake checker for the execution block
`timescale 1ns/1ps
`include "clx_consts.vh"
module clx_exec_asserts (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write channels
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Read channels
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("no bvalid");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no rvalid");
    property p_b_release;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_b_release: assert property (p_b_release) else $error("b stuck");
    property p_r_release;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_r_release: assert property (p_r_release) else $error("r stuck");
    property p_b_cause;
        $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_cause: assert property (p_b_cause) else $error("b uncaused");
    property p_resp_code;
        s_axi_bvalid |-> s_axi_bresp inside {`CLX_RESP_OK, `CLX_RESP_ERR};
    endproperty
    a_resp_code: assert property (p_resp_code) else $error("bad bresp");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h40 |=> s_axi_rresp == `CLX_RESP_ERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_aw_return;
        $fell(s_axi_awready) |-> ##[1:4] s_axi_awready;
    endproperty
    a_aw_return: assert property (p_aw_return) else $error("aw stuck");
endmodule // clx_exec_asserts

/* tb/tb_clx_exec.sv */
// Self-checking bench for the execution block
`timescale 1ns/1ps
`include "clx_consts.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_clx_exec;
    typedef struct {logic [4:0] op; logic [7:0] a, b, fl; logic ln; logic [7:0] ra; logic [21:0] ev, pc; logic [7:0] efl; logic [2:0] cyc;} clx_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [1:0] s_axi_bresp, s_axi_rresp, wresp, rresp;
    int num_errors = 0, checks_done = 0, cycles = 0;
    clx_row_t rows[24] = '{
        '{5'h00,8'h81,8'h06,8'h01,1'h0,8'h04,22'h87,22'h3f0101,8'h15,3'h1},
        '{5'h01,8'h0f,8'h0f,8'h10,1'h0,8'h04,22'h00,22'h3f0101,8'h02,3'h1},
        '{5'h02,8'h80,8'h00,8'h08,1'h0,8'h04,22'h80,22'h3f0101,8'h14,3'h1},
        '{5'h03,8'hff,8'hff,8'h06,1'h0,8'h1c,22'hfe01,22'h3f0101,8'h05,3'h2},
        '{5'h04,8'hff,8'h01,8'h00,1'h0,8'h1c,22'hffff,22'h3f0101,8'h01,3'h2},
        '{5'h05,8'hff,8'hff,8'h00,1'h0,8'h1c,22'hff01,22'h3f0101,8'h01,3'h2},
        '{5'h06,8'h80,8'h80,8'h03,1'h0,8'h1c,22'h8000,22'h3f0101,8'h00,3'h2},
        '{5'h07,8'h80,8'h80,8'h00,1'h0,8'h1c,22'h8000,22'h3f0101,8'h00,3'h2},
        '{5'h08,8'h00,8'h55,8'h01,1'h0,8'h1c,22'h0,22'h3f0101,8'h02,3'h2},
        '{5'h0a,8'h00,8'h00,8'h00,1'h0,8'h04,22'h0,22'h001234,8'h00,3'h2},
        '{5'h0b,8'h00,8'h00,8'h00,1'h0,8'h04,22'h0,22'h051234,8'h00,3'h2},
        '{5'h0c,8'h00,8'h00,8'h00,1'h0,8'h24,22'h3f0101,22'h001234,8'h00,3'h3},
        '{5'h0d,8'h00,8'h00,8'h00,1'h0,8'h24,22'h3f0101,22'h051234,8'h00,3'h3},
        '{5'h0e,8'h42,8'h42,8'h00,1'h0,8'h04,22'h42,22'h3f0102,8'h00,3'h2},
        '{5'h0e,8'h42,8'h43,8'h00,1'h1,8'h04,22'h42,22'h3f0101,8'h00,3'h1},
        '{5'h0f,8'hfe,8'h00,8'h00,1'h0,8'h04,22'hfe,22'h3f0102,8'h00,3'h2},
        '{5'h10,8'hfe,8'h01,8'h00,1'h1,8'h04,22'hfe,22'h3f0103,8'h00,3'h3},
        '{5'h11,8'h01,8'h00,8'h00,1'h0,8'h04,22'h01,22'h3f0101,8'h00,3'h2},
        '{5'h12,8'h01,8'h00,8'h00,1'h1,8'h04,22'h01,22'h3f0103,8'h00,3'h4},
        '{5'h13,8'h03,8'h05,8'h08,1'h0,8'h04,22'h03,22'h3f0106,8'h08,3'h2},
        '{5'h14,8'h03,8'h7f,8'h08,1'h0,8'h04,22'h03,22'h3f0101,8'h08,3'h1},
        '{5'h14,8'h03,8'h7f,8'h00,1'h0,8'h04,22'h03,22'h3f0100,8'h00,3'h2},
        '{5'h16,8'h00,8'h40,8'h01,1'h0,8'h04,22'h00,22'h3f00c1,8'h01,3'h2},
        '{5'h17,8'h00,8'h10,8'h01,1'h0,8'h04,22'h00,22'h3f0101,8'h01,3'h1}
    };
    clx_exec uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic report_and_stop;
        begin
            $display("checks %0d errors %0d", checks_done, num_errors);
            if (num_errors == 0 && checks_done > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors++;
            report_and_stop;
        end
    end
    task automatic wr(input [7:0] ad, input [31:0] d);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        wresp = s_axi_bresp;
    endtask
    task automatic rd(input [7:0] ad);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        rresp = s_axi_rresp;
    endtask
    task automatic run(input [4:0] op, input [7:0] a, b, fl, input ln);
        wr(8'h04, {24'h0, a});
        wr(8'h08, {24'h0, b});
        wr(8'h18, {24'h0, fl});
        wr(8'h0c, 32'h3f0100);
        wr(8'h00, {22'h0, ln, 1'b1, 3'h0, op});
        do rd(8'h20); while (rdv[0] === 1'b1);
    endtask
    initial begin
        aresetn = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h0c);
        `CHK("pc after reset", 32'h0, rdv)
        wr(8'h10, 32'h1234);
        wr(8'h14, 32'h05);
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].a, rows[i].b, rows[i].fl, rows[i].ln);
            `CHK("cycles", rows[i].cyc, rdv[7:5])
            rd(8'h0c);
            `CHK("pc", rows[i].pc, rdv)
            rd(8'h18);
            `CHK("flags", rows[i].efl, rdv)
            rd(rows[i].ra);
            `CHK("value", rows[i].ev, rdv)
        end
        wr(8'h30, 32'h01234567);
        wr(8'h34, 32'h89abcdef);
        wr(8'h38, 32'h0f1e2d3c);
        wr(8'h3c, 32'h4b5a6978);
        run(5'h09, 8'h00, 8'h03, 8'h00, 1'h0);
        `CHK("cyc1", 3'h2, rdv[7:5])
        run(5'h09, 8'h00, 8'h03, 8'h20, 1'h0);
        `CHK("cyc2", 3'h1, rdv[7:5])
        rd(8'h30);
        `CHK("block low", 32'h01234567, rdv)
        rd(8'h34);
        `CHK("block high", 32'h89abcdef, rdv)
        rd(8'h40);
        `CHK("bad rd", `CLX_RESP_ERR, rresp)
        wr(8'h44, 32'h1);
        `CHK("bad wr", `CLX_RESP_ERR, wresp)
        wr(8'h04, 32'h01);
        wr(8'h08, 32'h00);
        wr(8'h00, 32'h312);
        wr(8'h04, 32'h77);
        `CHK("busy wr", `CLX_RESP_ERR, wresp)
        do rd(8'h20); while (rdv[0] === 1'b1);
        rd(8'h04);
        `CHK("operand kept", 32'h01, rdv)
        wr(8'h0c, 32'h2a);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h0c);
        `CHK("pc rst2", 32'h0, rdv)
        report_and_stop;
    end
endmodule // tb_clx_exec
bind clx_exec clx_exec_asserts u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

/* verilog/clx_cipher.v */
// One keyed Feistel round over a 64-bit block and 64-bit key
`timescale 1ns/1ps
module clx_cipher (
    // Block and key
    input wire [63:0] block_in,
    input wire [63:0] key,
    input wire [3:0] round,
    input wire decrypt,
    // Result
    output wire [63:0] block_out
);
    wire [63:0] key_rot;
    wire [31:0] subkey;
    wire [31:0] left;
    wire [31:0] right;
    wire [31:0] f_enc;
    wire [31:0] f_dec;
    wire [31:0] mix_enc;
    wire [31:0] mix_dec;

    // Simplified round: not a standard cipher, only invertible per round
    assign key_rot = (key << round) | (key >> (7'h40 - {3'h0, round}));
    assign subkey = key_rot[31:0] ^ key_rot[63:32];
    assign left = block_in[63:32];
    assign right = block_in[31:0];
    assign mix_enc = right ^ subkey;
    assign mix_dec = left ^ subkey;
    assign f_enc = {mix_enc[30:0], mix_enc[31]} ^ {mix_enc[7:0], mix_enc[31:8]};
    assign f_dec = {mix_dec[30:0], mix_dec[31]} ^ {mix_dec[7:0], mix_dec[31:8]};
    // Decrypt undoes encrypt for the same round and key
    assign block_out = decrypt ? {right ^ f_dec, left} : {right, left ^ f_enc};
endmodule // clx_cipher

/* verilog/clx_consts.vh */
// Constants for the logic, multiply and branch execution block
// How it works
// - Or-mask: destination OR immediate, flags Z N V S, one cycle.
// - Clear-mask: destination AND inverted immediate, flags Z N V S, one cycle.
// - Zero-sign test: register AND itself, value kept, flags Z N V S, one cycle.
// - Three 8x8 multiplies into pair one:zero, only Z and C, two cycles.
// - Fractional multiplies: product shifted left one into pair one:zero, two cycles.
// - Cipher round on registers fifteen..zero with round K; H selects decrypt; one/two cycles.
// - Pointer jump: PC low from Z, upper bits cleared, two cycles.
// - Far pointer jump: PC low from Z, upper from page register, two cycles.
// - Pointer call: target Z, upper cleared, two or three cycles by PC width.
// - Far pointer call: upper PC bits from page register, three cycles.
// - Compare registers, skip next when equal; one, two or three cycles.
// - Skip when register bit clear, or set for the twin; one to three cycles.
// - Skip when I/O bit clear, or set for the twin; two to four cycles.
// - Branch PC+k+1 when chosen flag set; one cycle untaken, two taken.
// - Branch PC+k+1 when chosen flag clear; one cycle untaken, two taken.
// - Carry-clear branch on C=0, carry-set branch on C=1, one or two cycles.
// - Same-or-higher branch behaves exactly as the carry-clear branch.
`ifndef CLX_CONSTS_VH
`define CLX_CONSTS_VH

// Register byte offsets
`define CLX_OFF_CTRL 8'h00
`define CLX_OFF_OPA 8'h04
`define CLX_OFF_OPB 8'h08
`define CLX_OFF_PC 8'h0c
`define CLX_OFF_ZPTR 8'h10
`define CLX_OFF_PAGE 8'h14
`define CLX_OFF_STATUS_FLAGS_REGISTER 8'h18
`define CLX_OFF_RESULT 8'h1c
`define CLX_OFF_STATUS 8'h20
`define CLX_OFF_RETADDR 8'h24
`define CLX_OFF_CIPH0 8'h30

// Control register fields
`define CLX_CTRL_OP_HI 4
`define CLX_CTRL_GO 8
`define CLX_CTRL_LONG 9

// Status flag bit positions
`define CLX_F_C 0
`define CLX_F_Z 1
`define CLX_F_N 2
`define CLX_F_V 3
`define CLX_F_S 4
`define CLX_F_H 5

// Operation codes
`define CLX_OP_OR_MASK 5'h00
`define CLX_OP_CLR_MASK 5'h01
`define CLX_OP_TEST 5'h02
`define CLX_OP_MUL_UU 5'h03
`define CLX_OP_MUL_SS 5'h04
`define CLX_OP_MUL_SU 5'h05
`define CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_UU 5'h06
`define CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_SS 5'h07
`define CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_SU 5'h08
`define CLX_OP_CIPHER 5'h09
`define CLX_OP_JMP_Z 5'h0a
`define CLX_OP_FJMP_Z 5'h0b
`define CLX_OP_CALL_Z 5'h0c
`define CLX_OP_FCALL_Z 5'h0d
`define CLX_OP_COMPARE_SKIP_EQUAL 5'h0e
`define CLX_OP_SKIP_RLO 5'h0f
`define CLX_OP_SKIP_RHI 5'h10
`define CLX_OP_SKIP_IOLO 5'h11
`define CLX_OP_SKIP_IOHI 5'h12
`define CLX_OP_BR_FHI 5'h13
`define CLX_OP_BR_FLO 5'h14
`define CLX_OP_BR_CLO 5'h15
`define CLX_OP_BR_CHI 5'h16
`define CLX_OP_BR_SH 5'h17

// Cycle counts
`define CLX_CYC_ONE 3'h1
`define CLX_CYC_TWO 3'h2
`define CLX_CYC_THREE 3'h3
`define CLX_CYC_FOUR 3'h4

// AXI responses
`define CLX_RESP_OK 2'h0
`define CLX_RESP_ERR 2'h2

`endif

/* verilog/clx_exec.v */
// Execution unit for logic, multiply, cipher, jump, skip and branch operations
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "clx_consts.vh"
module clx_exec #(
    parameter PC_WIDTH = 22
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    localparam [21:0] PC_STEP1 = 22'h000001;
    localparam [21:0] PC_STEP2 = 22'h000002;
    localparam [21:0] PC_STEP3 = 22'h000003;
    localparam [2:0] CALL_CYC = (PC_WIDTH > 16) ? `CLX_CYC_THREE : `CLX_CYC_TWO;

    // Architectural state
    reg [21:0] pc;
    reg [15:0] zptr;
    reg [5:0] extended_indirect_page;
    reg [7:0] status_flags_register;
    reg [7:0] opa;
    reg [7:0] opb;
    reg [15:0] result;
    reg [21:0] retaddr;
    reg [31:0] ciph_word [0:3];
    // Sequencing
    reg busy;
    reg [2:0] cyc_left;
    reg [2:0] cyc_used;
    reg [4:0] op_cur;
    reg took;
    reg bad_op;
    reg prev_cipher;
    reg [21:0] pend_pc;
    reg [7:0] pend_flags;
    reg [7:0] pend_res;
    reg pend_wr;
    // AXI capture
    reg aw_got;
    reg w_got;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire do_write;
    wire launch;
    wire [4:0] w_op;
    wire is_mul;
    wire mul_signed_a;
    wire mul_signed_b;
    wire mul_frac;
    wire [15:0] mul_product;
    wire mul_zero;
    wire mul_carry;
    wire [63:0] ciph_out;
    wire [7:0] aligned_aw;
    wire [7:0] aligned_ar;

    // Combinational launch decisions
    reg [21:0] l_pc;
    reg [7:0] l_flags;
    reg [7:0] l_res;
    reg l_wr;
    reg [2:0] l_cyc;
    reg l_took;
    reg l_bad;
    reg [7:0] lg;
    reg [21:0] skip_pc;
    reg [2:0] skip_cyc;
    reg [21:0] br_pc;
    reg [31:0] rd_mux;
    reg rd_ok;
    reg wr_ok;

    assign aligned_aw = {aw_addr[7:2], 2'b00};
    assign aligned_ar = {s_axi_araddr[7:2], 2'b00};
    assign do_write = aw_got && w_got && !s_axi_bvalid;
    assign w_op = w_data[`CLX_CTRL_OP_HI:0];
    assign launch = do_write && !busy && (aligned_aw == `CLX_OFF_CTRL) && w_strb[0] && w_strb[1]
        && w_data[`CLX_CTRL_GO];
    assign is_mul = (w_op >= `CLX_OP_MUL_UU) && (w_op <= `CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_SU);
    assign mul_frac = (w_op >= `CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_UU);
    assign mul_signed_a = (w_op == `CLX_OP_MUL_SS) || (w_op == `CLX_OP_MUL_SU)
        || (w_op == `CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_SS) || (w_op == `CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_SU);
    assign mul_signed_b = (w_op == `CLX_OP_MUL_SS) || (w_op == `CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_SS);

    clx_mul u_mul (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(launch && is_mul),
        .a(opa),
        .b(opb),
        .signed_a(mul_signed_a),
        .signed_b(mul_signed_b),
        .frac(mul_frac),
        .product(mul_product),
        .zero(mul_zero),
        .carry(mul_carry)
    );

    // Registers seven..zero form the block, fifteen..eight the key
    clx_cipher u_cipher (
        .block_in({ciph_word[1], ciph_word[0]}),
        .key({ciph_word[3], ciph_word[2]}),
        .round(opb[3:0]),
        .decrypt(status_flags_register[`CLX_F_H]),
        .block_out(ciph_out)
    );

    // Next PC, flags and cycle count decided at launch
    always @* begin
        l_pc = pc + PC_STEP1;
        l_flags = status_flags_register;
        l_res = opa;
        l_wr = 1'b0;
        l_cyc = `CLX_CYC_ONE;
        l_took = 1'b0;
        l_bad = 1'b0;
        lg = opa;
        skip_pc = pc + (w_data[`CLX_CTRL_LONG] ? PC_STEP3 : PC_STEP2);
        skip_cyc = w_data[`CLX_CTRL_LONG] ? `CLX_CYC_THREE : `CLX_CYC_TWO;
        br_pc = pc + {{15{opb[6]}}, opb[6:0]} + PC_STEP1;
        case (w_op)
            `CLX_OP_OR_MASK: lg = opa | opb;
            `CLX_OP_CLR_MASK: lg = opa & ~opb;
            `CLX_OP_TEST: lg = opa & opa;
            default: lg = opa;
        endcase
        case (w_op)
            `CLX_OP_OR_MASK, `CLX_OP_CLR_MASK, `CLX_OP_TEST: begin
                l_res = lg;
                l_wr = (w_op != `CLX_OP_TEST);
                l_flags[`CLX_F_Z] = (lg == 8'h00);
                l_flags[`CLX_F_N] = lg[7];
                l_flags[`CLX_F_V] = 1'b0;
                l_flags[`CLX_F_S] = lg[7] ^ 1'b0;
            end
            `CLX_OP_MUL_UU, `CLX_OP_MUL_SS, `CLX_OP_MUL_SU,
            `CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_UU, `CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_SS, `CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_SU: begin
                l_cyc = `CLX_CYC_TWO;
            end
            `CLX_OP_CIPHER: begin
                // Back-to-back rounds issue in one cycle, a first round in two
                l_cyc = prev_cipher ? `CLX_CYC_ONE : `CLX_CYC_TWO;
            end
            `CLX_OP_JMP_Z: begin
                l_pc = {6'h00, zptr};
                l_cyc = `CLX_CYC_TWO;
            end
            `CLX_OP_FJMP_Z: begin
                l_pc = {extended_indirect_page, zptr};
                l_cyc = `CLX_CYC_TWO;
            end
            `CLX_OP_CALL_Z: begin
                l_pc = {6'h00, zptr};
                l_cyc = CALL_CYC;
            end
            `CLX_OP_FCALL_Z: begin
                l_pc = {extended_indirect_page, zptr};
                l_cyc = `CLX_CYC_THREE;
            end
            `CLX_OP_COMPARE_SKIP_EQUAL: begin
                if (opa == opb) begin
                    l_pc = skip_pc;
                    l_cyc = skip_cyc;
                    l_took = 1'b1;
                end
            end
            `CLX_OP_SKIP_RLO, `CLX_OP_SKIP_RHI: begin
                if (opa[opb[2:0]] == (w_op == `CLX_OP_SKIP_RHI)) begin
                    l_pc = skip_pc;
                    l_cyc = skip_cyc;
                    l_took = 1'b1;
                end
            end
            `CLX_OP_SKIP_IOLO, `CLX_OP_SKIP_IOHI: begin
                // I/O read costs one extra cycle on every path
                l_cyc = `CLX_CYC_TWO;
                if (opa[opb[2:0]] == (w_op == `CLX_OP_SKIP_IOHI)) begin
                    l_pc = skip_pc;
                    l_cyc = w_data[`CLX_CTRL_LONG] ? `CLX_CYC_FOUR : `CLX_CYC_THREE;
                    l_took = 1'b1;
                end
            end
            `CLX_OP_BR_FHI, `CLX_OP_BR_FLO: begin
                if (status_flags_register[opa[2:0]] == (w_op == `CLX_OP_BR_FHI)) begin
                    l_pc = br_pc;
                    l_cyc = `CLX_CYC_TWO;
                    l_took = 1'b1;
                end
            end
            `CLX_OP_BR_CLO, `CLX_OP_BR_SH, `CLX_OP_BR_CHI: begin
                if (status_flags_register[`CLX_F_C] == (w_op == `CLX_OP_BR_CHI)) begin
                    l_pc = br_pc;
                    l_cyc = `CLX_CYC_TWO;
                    l_took = 1'b1;
                end
            end
            default: begin
                l_bad = 1'b1;
                l_pc = pc;
            end
        endcase
    end

    // Register write acceptance; state registers refuse writes while busy
    always @* begin
        wr_ok = 1'b1;
        case (aligned_aw)
            `CLX_OFF_CTRL: wr_ok = !busy;
            `CLX_OFF_OPA, `CLX_OFF_OPB, `CLX_OFF_PC, `CLX_OFF_ZPTR,
            `CLX_OFF_PAGE, `CLX_OFF_STATUS_FLAGS_REGISTER, `CLX_OFF_RESULT: wr_ok = !busy;
            `CLX_OFF_CIPH0, 8'h34, 8'h38, 8'h3c: wr_ok = !busy;
            default: wr_ok = 1'b0;
        endcase
    end

    always @* begin
        rd_ok = 1'b1;
        rd_mux = 32'h00000000;
        case (aligned_ar)
            `CLX_OFF_CTRL: rd_mux = {27'h0000000, op_cur};
            `CLX_OFF_OPA: rd_mux = {24'h000000, opa};
            `CLX_OFF_OPB: rd_mux = {24'h000000, opb};
            `CLX_OFF_PC: rd_mux = {10'h000, pc};
            `CLX_OFF_ZPTR: rd_mux = {16'h0000, zptr};
            `CLX_OFF_PAGE: rd_mux = {26'h0000000, extended_indirect_page};
            `CLX_OFF_STATUS_FLAGS_REGISTER: rd_mux = {24'h000000, status_flags_register};
            `CLX_OFF_RESULT: rd_mux = {16'h0000, result};
            `CLX_OFF_STATUS: rd_mux = {24'h000000, cyc_used, prev_cipher, bad_op, took, 1'b0, busy};
            `CLX_OFF_RETADDR: rd_mux = {10'h000, retaddr};
            `CLX_OFF_CIPH0: rd_mux = ciph_word[0];
            8'h34: rd_mux = ciph_word[1];
            8'h38: rd_mux = ciph_word[2];
            8'h3c: rd_mux = ciph_word[3];
            default: rd_ok = 1'b0;
        endcase
    end

    // AXI4-Lite handshakes: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CLX_RESP_OK;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `CLX_RESP_OK;
            s_axi_rdata <= 32'h00000000;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `CLX_RESP_OK : `CLX_RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `CLX_RESP_OK : `CLX_RESP_ERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Software writes, launch and commit
    always @(posedge aclk) begin
        if (!aresetn) begin
            pc <= 22'h000000;
            zptr <= 16'h0000;
            extended_indirect_page <= 6'h00;
            status_flags_register <= 8'h00;
            opa <= 8'h00;
            opb <= 8'h00;
            result <= 16'h0000;
            retaddr <= 22'h000000;
            ciph_word[0] <= 32'h00000000;
            ciph_word[1] <= 32'h00000000;
            ciph_word[2] <= 32'h00000000;
            ciph_word[3] <= 32'h00000000;
            busy <= 1'b0;
            cyc_left <= 3'h0;
            cyc_used <= 3'h0;
            op_cur <= 5'h00;
            took <= 1'b0;
            bad_op <= 1'b0;
            prev_cipher <= 1'b0;
            pend_pc <= 22'h000000;
            pend_flags <= 8'h00;
            pend_res <= 8'h00;
            pend_wr <= 1'b0;
        end else if (launch) begin
            busy <= 1'b1;
            op_cur <= w_op;
            cyc_left <= l_cyc - `CLX_CYC_ONE;
            cyc_used <= l_cyc;
            took <= l_took;
            bad_op <= l_bad;
            pend_pc <= l_pc;
            pend_flags <= l_flags;
            pend_res <= l_res;
            pend_wr <= l_wr;
            if ((w_op == `CLX_OP_CALL_Z) || (w_op == `CLX_OP_FCALL_Z)) begin
                retaddr <= pc + PC_STEP1;
            end
        end else if (busy) begin
            if (cyc_left != 3'h0) begin
                cyc_left <= cyc_left - `CLX_CYC_ONE;
            end else begin
                // All effects except the return address (written at launch) land together at the final cycle
                busy <= 1'b0;
                pc <= pend_pc;
                prev_cipher <= (op_cur == `CLX_OP_CIPHER);
                if (pend_wr) begin
                    opa <= pend_res;
                end
                if ((op_cur >= `CLX_OP_MUL_UU) && (op_cur <= `CLX_OP_FRACTIONAL_PRODUCT_UNSIGNED_SU)) begin
                    result <= mul_product;
                    status_flags_register <= {status_flags_register[7:2], mul_zero, mul_carry};
                end else begin
                    status_flags_register <= pend_flags;
                end
                if (op_cur == `CLX_OP_CIPHER) begin
                    ciph_word[0] <= ciph_out[31:0];
                    ciph_word[1] <= ciph_out[63:32];
                end
            end
        end else if (do_write && wr_ok) begin
            case (aligned_aw)
                `CLX_OFF_OPA: opa <= w_data[7:0];
                `CLX_OFF_OPB: opb <= w_data[7:0];
                `CLX_OFF_PC: pc <= w_data[21:0];
                `CLX_OFF_ZPTR: zptr <= w_data[15:0];
                `CLX_OFF_PAGE: extended_indirect_page <= w_data[5:0];
                `CLX_OFF_STATUS_FLAGS_REGISTER: status_flags_register <= w_data[7:0];
                `CLX_OFF_RESULT: result <= w_data[15:0];
                `CLX_OFF_CIPH0: ciph_word[0] <= w_data;
                8'h34: ciph_word[1] <= w_data;
                8'h38: ciph_word[2] <= w_data;
                8'h3c: ciph_word[3] <= w_data;
                default: prev_cipher <= prev_cipher;
            endcase
            if (aligned_aw == `CLX_OFF_CTRL) begin
                prev_cipher <= 1'b0;
            end
        end
    end
endmodule // clx_exec

/* verilog/clx_mul.v */
// Registered 8x8 multiplier with signed, unsigned and fractional forms
`timescale 1ns/1ps
module clx_mul (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Request
    input wire start,
    input wire [7:0] a,
    input wire [7:0] b,
    input wire signed_a,
    input wire signed_b,
    input wire frac,
    // Result
    output reg [15:0] product,
    output reg zero,
    output reg carry
);
    wire [15:0] ext_a;
    wire [15:0] ext_b;
    wire [31:0] full;
    wire [15:0] raw;
    wire [15:0] shaped;

    // Low 16 bits of the extended product are exact for all sign mixes
    assign ext_a = {{8{signed_a & a[7]}}, a};
    assign ext_b = {{8{signed_b & b[7]}}, b};
    assign full = ext_a * ext_b;
    assign raw = full[15:0];
    assign shaped = frac ? {raw[14:0], 1'b0} : raw;

    always @(posedge aclk) begin
        if (!aresetn) begin
            product <= 16'h0000;
            zero <= 1'b0;
            carry <= 1'b0;
        end else if (start) begin
            product <= shaped;
            zero <= (shaped == 16'h0000);
            // Carry is the product's top bit before any fractional shift
            carry <= raw[15];
        end
    end
endmodule // clx_mul
